// ### hdl/pafm_mux.sv
`timescale 1ns/1ps
// Summary of operation
// (R1) Serial channels reset halted, output disabled, data and clock levels high.
// (R2) Timer output enables reset cleared, timer levels low.
// (R3) I2C enable resets to 0; halted unit presents low outputs.
// (R4) Clock/buzzer enable resets to 0; disabled output presents low.
// (R5) Single-bit port write: read 8 bits, modify one, write 8 back.
// (R6) Port read gives latch for output bits, pin level for input bits.
// (R7) Software rewrites the latch before turning an input into output.
// (R8) Input pins keep every output buffer off.
// (R9) Software keeps unused shared functions at their reset state.
// (R10) Software disables unused peripheral units to save power.
// (R11) External interrupt 1 from pin 0 or pin 3 by redirect bit.
// (R12) Non-serial output needs digital, output direction, latch 0.
// (R13) Serial output needs digital, output direction, latch 1.
// (R14) Pin out is latch AND serial, ORed with non-serial outputs.
// (R15) Software sets analog pins to input direction too.
// (R16) Oscillator pins: port at 00/10, resonator 01, external clock 11.
module pafm_mux (
	input wire logic ref_clk, // System clock, 50 MHz
	input wire logic rstn, // Async reset, active low
	input wire logic [7:0] addr, // Register address
	input wire logic [7:0] wdata, // Write data
	input wire logic wr, // Write strobe
	input wire logic rd, // Read strobe
	output logic [7:0] rdata, // Read data, cycle after rd
	input wire pafm_pkg::pafm_periph_t periph, // Peripheral raw outputs
	input wire logic [8:0] pin_in, // Pin levels, bit 8 is aux pin
	output logic [8:0] pin_out, // Pin output levels
	output logic [8:0] pin_oe_n, // Pin output enables, low drives
	output logic ext_irq_1, // External interrupt 1 input
	output logic [1:0] ser_run, // Serial channel run bits
	output logic i2c_unit_enable, // I2C unit enable
	output logic clk_buzzer_out_enable, // Clock/buzzer enable
	output logic osc_port_mode, // Oscillator pins are ports
	output logic osc_resonator_en, // Resonator connected
	output logic osc_ext_clk_en // External clock input
);
	import pafm_pkg::*;

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic [7:0] port_latch_reg, next_port_latch_reg;
	logic [7:0] direction_reg, next_direction_reg;
	logic [7:0] analog_select_reg, next_analog_select_reg;
	logic [7:0] open_drain_select_reg, next_open_drain_select_reg;
	logic [2:0] pin_redirect_reg, next_pin_redirect_reg;
	logic [1:0] next_ser_run;
	logic [1:0] serial_output_enable_reg, next_serial_output_enable_reg;
	logic [1:0] serial_data_out_level, next_serial_data_out_level;
	logic [1:0] serial_clock_out_level, next_serial_clock_out_level;
	logic [3:0] timer_output_enable_reg, next_timer_output_enable_reg;
	logic [3:0] timer_output_level_reg, next_timer_output_level_reg;
	logic next_i2c_unit_enable;
	logic next_clk_buzzer_out_enable;
	logic [1:0] clk_pin_mode_reg, next_clk_pin_mode_reg;
	logic clk_mode_locked, next_clk_mode_locked;
	logic [1:0] aux_reg, next_aux_reg;
	logic [7:0] next_rdata;

	// Read-modify-write sequencer state
	pafm_rmw_st_t rmw_st, next_rmw_st;
	logic [2:0] rmw_idx, next_rmw_idx;
	logic rmw_val, next_rmw_val;
	logic [7:0] rmw_work, next_rmw_work;

	// Derived levels
	logic [7:0] port_view;
	logic [1:0] ser_d_eff, ser_c_eff;
	logic [3:0] tmr_eff;
	logic i2c_scl_eff, i2c_sda_eff, buz_eff;
	logic [8:0] cell_latch, cell_ser, cell_nonser, cell_dir, cell_an, cell_od;
	logic next_ext_irq_1;
	logic next_osc_port_mode, next_osc_resonator_en, next_osc_ext_clk_en;

	// ****************************************************************
	// Peripheral output gating and port view
	// ****************************************************************
	// A halted or disabled unit shows its idle level, never raw output
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			ser_d_eff[i] = (ser_run[i] && serial_output_enable_reg[i]) ?
				periph.ser_data[i] : serial_data_out_level[i]; // R1
			ser_c_eff[i] = (ser_run[i] && serial_output_enable_reg[i]) ?
				periph.ser_clk[i] : serial_clock_out_level[i]; // R1
		end
		for (int i = 0; i < 4; i++) begin
			tmr_eff[i] = timer_output_enable_reg[i] ?
				periph.tmr[i] : timer_output_level_reg[i]; // R2
		end
		i2c_scl_eff = i2c_unit_enable & periph.i2c_scl; // R3
		i2c_sda_eff = i2c_unit_enable & periph.i2c_sda; // R3
		buz_eff = clk_buzzer_out_enable & periph.buz; // R4
		// Output bits read the latch, input bits read the pin
		port_view = (port_latch_reg & ~direction_reg) |
			(pin_in[7:0] & direction_reg); // R6
	end

	// ****************************************************************
	// Pin routing
	// ****************************************************************
	// Serial inputs idle high, non-serial inputs idle low
	always_comb begin
		cell_latch = {aux_reg[PAFM_AUX_LATCH], port_latch_reg};
		cell_dir = {aux_reg[PAFM_AUX_DIR], direction_reg};
		cell_an = {1'b0, analog_select_reg};
		cell_od = {1'b0, open_drain_select_reg};
		cell_ser = {1'b1, ser_c_eff[1], 1'b1, ser_d_eff[1], 2'h3,
			ser_c_eff[0], 1'b1, ser_d_eff[0]};
		cell_nonser = '0;
		cell_nonser[2] = buz_eff & !pin_redirect_reg[PAFM_REDIR_BUZ];
		cell_nonser[3] = tmr_eff[0];
		cell_nonser[4] = tmr_eff[1] & !pin_redirect_reg[PAFM_REDIR_TMR1];
		cell_nonser[5] = tmr_eff[2];
		cell_nonser[6] = i2c_scl_eff;
		cell_nonser[7] = tmr_eff[3] | i2c_sda_eff;
		// Redirected functions share the aux pin; both set is illegal use
		cell_nonser[8] = (buz_eff & pin_redirect_reg[PAFM_REDIR_BUZ]) |
			(tmr_eff[1] & pin_redirect_reg[PAFM_REDIR_TMR1]);
	end

	genvar g;
	generate
		for (g = 0; g < 9; g++) begin : g_pin
			pafm_pin_cell u_cell (
				.ref_clk(ref_clk),
				.rstn(rstn),
				.latch(cell_latch[g]),
				.ser(cell_ser[g]),
				.nonser(cell_nonser[g]),
				.dir_in(cell_dir[g]),
				.analog(cell_an[g]),
				.open_drain(cell_od[g]),
				.pin_out(pin_out[g]),
				.pin_oe_n(pin_oe_n[g])
			);
		end
	endgenerate

	// ****************************************************************
	// Register writes, reads and bit sequencer
	// ****************************************************************
	// A direct port write in the sequencer's write cycle is overwritten
	always_comb begin
		next_port_latch_reg = port_latch_reg;
		next_direction_reg = direction_reg;
		next_analog_select_reg = analog_select_reg;
		next_open_drain_select_reg = open_drain_select_reg;
		next_pin_redirect_reg = pin_redirect_reg;
		next_ser_run = ser_run;
		next_serial_output_enable_reg = serial_output_enable_reg;
		next_serial_data_out_level = serial_data_out_level;
		next_serial_clock_out_level = serial_clock_out_level;
		next_timer_output_enable_reg = timer_output_enable_reg;
		next_timer_output_level_reg = timer_output_level_reg;
		next_i2c_unit_enable = i2c_unit_enable;
		next_clk_buzzer_out_enable = clk_buzzer_out_enable;
		next_clk_pin_mode_reg = clk_pin_mode_reg;
		next_clk_mode_locked = clk_mode_locked;
		next_aux_reg = aux_reg;
		next_rmw_st = rmw_st;
		next_rmw_idx = rmw_idx;
		next_rmw_val = rmw_val;
		next_rmw_work = rmw_work;
		if (wr) begin
			unique case (addr)
				PAFM_OFF_PORT: next_port_latch_reg = wdata;
				PAFM_OFF_DIR: next_direction_reg = wdata;
				PAFM_OFF_ANALOG: next_analog_select_reg = wdata;
				PAFM_OFF_ODRAIN: next_open_drain_select_reg = wdata;
				PAFM_OFF_REDIR: next_pin_redirect_reg = wdata[2:0];
				PAFM_OFF_SER_CTRL: begin
					next_ser_run = wdata[1:0];
					next_serial_output_enable_reg = wdata[3:2];
				end
				PAFM_OFF_SER_LEV: begin
					next_serial_data_out_level = wdata[1:0];
					next_serial_clock_out_level = wdata[3:2];
				end
				PAFM_OFF_TMR_OE: next_timer_output_enable_reg = wdata[3:0];
				PAFM_OFF_TMR_LEV: next_timer_output_level_reg = wdata[3:0];
				PAFM_OFF_MISC: begin
					next_i2c_unit_enable = wdata[PAFM_MISC_I2C];
					next_clk_buzzer_out_enable = wdata[PAFM_MISC_BUZ];
				end
				// Pin mode may only be set once, so a runaway write cannot move it
				PAFM_OFF_CLK_MODE: if (!clk_mode_locked) begin
					next_clk_pin_mode_reg = {wdata[PAFM_CM_EXT], wdata[PAFM_CM_OSC]};
					next_clk_mode_locked = 1'b1;
				end
				PAFM_OFF_BITOP: if (rmw_st == PAFM_S_IDLE) begin
					next_rmw_idx = wdata[2:0];
					next_rmw_val = wdata[PAFM_BITOP_VAL];
					next_rmw_st = PAFM_S_READ;
				end
				PAFM_OFF_AUX: next_aux_reg = wdata[1:0];
				default: ;
			endcase
		end
		// Whole byte is read, so input bits pick up their pin levels
		unique case (rmw_st)
			PAFM_S_IDLE: ;
			PAFM_S_READ: begin
				next_rmw_work = port_view; // R5
				next_rmw_st = PAFM_S_MODIFY;
			end
			PAFM_S_MODIFY: begin
				next_rmw_work[rmw_idx] = rmw_val; // R5
				next_rmw_st = PAFM_S_WRITE;
			end
			PAFM_S_WRITE: begin
				next_port_latch_reg = rmw_work; // R5
				next_rmw_st = PAFM_S_IDLE;
			end
		endcase
		next_rdata = '0;
		if (rd) begin
			unique case (addr)
				PAFM_OFF_PORT: next_rdata = port_view; // R6
				PAFM_OFF_DIR: next_rdata = direction_reg;
				PAFM_OFF_ANALOG: next_rdata = analog_select_reg;
				PAFM_OFF_ODRAIN: next_rdata = open_drain_select_reg;
				PAFM_OFF_REDIR: next_rdata = {5'h00, pin_redirect_reg};
				PAFM_OFF_SER_CTRL: next_rdata = {4'h0, serial_output_enable_reg, ser_run};
				PAFM_OFF_SER_LEV:
					next_rdata = {4'h0, serial_clock_out_level, serial_data_out_level};
				PAFM_OFF_TMR_OE: next_rdata = {4'h0, timer_output_enable_reg};
				PAFM_OFF_TMR_LEV: next_rdata = {4'h0, timer_output_level_reg};
				PAFM_OFF_MISC: next_rdata = {6'h00, clk_buzzer_out_enable, i2c_unit_enable};
				PAFM_OFF_CLK_MODE: next_rdata = {clk_pin_mode_reg, 6'h00};
				PAFM_OFF_STATUS: next_rdata = {6'h00, clk_mode_locked, rmw_st != PAFM_S_IDLE};
				PAFM_OFF_AUX: next_rdata = {6'h00, aux_reg[PAFM_AUX_DIR],
					aux_reg[PAFM_AUX_DIR] ? pin_in[8] : aux_reg[PAFM_AUX_LATCH]};
				default: next_rdata = '0;
			endcase
		end
		next_ext_irq_1 = pin_redirect_reg[PAFM_REDIR_IRQ1] ?
			pin_in[PAFM_IRQ1_PIN_B] : pin_in[PAFM_IRQ1_PIN_A]; // R11
		next_osc_resonator_en = clk_pin_mode_reg == PAFM_OSC_RESONATOR; // R16
		next_osc_ext_clk_en = clk_pin_mode_reg == PAFM_OSC_EXT_CLK; // R16
		next_osc_port_mode = !clk_pin_mode_reg[0]; // R16
	end

	// Every state element resets to its idle, non-disturbing value
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			port_latch_reg <= PAFM_RST_ZERO;
			direction_reg <= PAFM_RST_DIR;
			analog_select_reg <= PAFM_RST_ANALOG;
			open_drain_select_reg <= PAFM_RST_ZERO;
			pin_redirect_reg <= '0;
			ser_run <= '0; // R1
			serial_output_enable_reg <= '0; // R1
			serial_data_out_level <= PAFM_RST_SER_LEV[1:0]; // R1
			serial_clock_out_level <= PAFM_RST_SER_LEV[3:2]; // R1
			timer_output_enable_reg <= '0; // R2
			timer_output_level_reg <= '0; // R2
			i2c_unit_enable <= 1'b0; // R3
			clk_buzzer_out_enable <= 1'b0; // R4
			clk_pin_mode_reg <= '0;
			clk_mode_locked <= 1'b0;
			aux_reg <= PAFM_RST_AUX;
			rmw_st <= PAFM_S_IDLE;
			rmw_idx <= '0;
			rmw_val <= 1'b0;
			rmw_work <= PAFM_RST_ZERO;
			rdata <= PAFM_RST_ZERO;
			ext_irq_1 <= 1'b0;
			osc_port_mode <= 1'b1;
			osc_resonator_en <= 1'b0;
			osc_ext_clk_en <= 1'b0;
		end else begin
			port_latch_reg <= next_port_latch_reg;
			direction_reg <= next_direction_reg;
			analog_select_reg <= next_analog_select_reg;
			open_drain_select_reg <= next_open_drain_select_reg;
			pin_redirect_reg <= next_pin_redirect_reg;
			ser_run <= next_ser_run;
			serial_output_enable_reg <= next_serial_output_enable_reg;
			serial_data_out_level <= next_serial_data_out_level;
			serial_clock_out_level <= next_serial_clock_out_level;
			timer_output_enable_reg <= next_timer_output_enable_reg;
			timer_output_level_reg <= next_timer_output_level_reg;
			i2c_unit_enable <= next_i2c_unit_enable;
			clk_buzzer_out_enable <= next_clk_buzzer_out_enable;
			clk_pin_mode_reg <= next_clk_pin_mode_reg;
			clk_mode_locked <= next_clk_mode_locked;
			aux_reg <= next_aux_reg;
			rmw_st <= next_rmw_st;
			rmw_idx <= next_rmw_idx;
			rmw_val <= next_rmw_val;
			rmw_work <= next_rmw_work;
			rdata <= next_rdata;
			ext_irq_1 <= next_ext_irq_1;
			osc_port_mode <= next_osc_port_mode;
			osc_resonator_en <= next_osc_resonator_en;
			osc_ext_clk_en <= next_osc_ext_clk_en;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	a_serial_idle_level: assert property ((ser_run[0] == 1'b0) |-> // R1
		(ser_d_eff[0] == serial_data_out_level[0] &&
		ser_c_eff[0] == serial_clock_out_level[0]))
		else $error("halted serial channel leaks raw output");
	a_timer_idle_level: assert property (!timer_output_enable_reg[0] |-> // R2
		tmr_eff[0] == timer_output_level_reg[0])
		else $error("disabled timer leaks raw output");
	a_i2c_halt_low: assert property (!i2c_unit_enable |-> // R3
		!i2c_scl_eff && !i2c_sda_eff)
		else $error("halted i2c drives high");
	a_buzzer_off_low: assert property (!clk_buzzer_out_enable |-> // R4
		!cell_nonser[2] && !buz_eff)
		else $error("disabled buzzer drives high");
	a_bitop_three_steps: assert property ( // R5
		(wr && addr == PAFM_OFF_BITOP && rmw_st == PAFM_S_IDLE) |=>
		rmw_st == PAFM_S_READ ##1 rmw_st == PAFM_S_MODIFY ##1
		rmw_st == PAFM_S_WRITE ##1 (port_latch_reg == $past(rmw_work) &&
		rmw_st == PAFM_S_IDLE))
		else $error("bit write sequence broken");
	a_port_read_mix: assert property ((rd && addr == PAFM_OFF_PORT) |=> // R6
		rdata == $past(port_view))
		else $error("port read returns wrong mix");
	a_irq1_source: assert property (rstn |=> ext_irq_1 == // R11
		($past(pin_redirect_reg[PAFM_REDIR_IRQ1]) ? $past(pin_in[PAFM_IRQ1_PIN_B]) :
		$past(pin_in[PAFM_IRQ1_PIN_A])))
		else $error("interrupt 1 taken from wrong pin");
	a_osc_pin_mode: assert property (rstn |=> (osc_ext_clk_en == // R16
		($past(clk_pin_mode_reg) == PAFM_OSC_EXT_CLK) &&
		osc_port_mode == !$past(clk_pin_mode_reg[0])))
		else $error("oscillator pin mode mismatch");

	c_bitop_done: cover property (rmw_st == PAFM_S_WRITE);
	c_irq1_redirect: cover property (pin_redirect_reg[PAFM_REDIR_IRQ1] && ext_irq_1);
	c_ext_clock: cover property (osc_ext_clk_en);
	c_aux_buzzer: cover property (cell_nonser[8] && !pin_oe_n[8]);
endmodule

// ### hdl/pafm_pkg.sv
package pafm_pkg;

	// ****************************************************************
	// Register offsets (8-bit word address)
	// ****************************************************************
	localparam logic [7:0] PAFM_OFF_PORT = 8'h00;
	localparam logic [7:0] PAFM_OFF_DIR = 8'h01;
	localparam logic [7:0] PAFM_OFF_ANALOG = 8'h02;
	localparam logic [7:0] PAFM_OFF_ODRAIN = 8'h03;
	localparam logic [7:0] PAFM_OFF_REDIR = 8'h04;
	localparam logic [7:0] PAFM_OFF_SER_CTRL = 8'h05;
	localparam logic [7:0] PAFM_OFF_SER_LEV = 8'h06;
	localparam logic [7:0] PAFM_OFF_TMR_OE = 8'h07;
	localparam logic [7:0] PAFM_OFF_TMR_LEV = 8'h08;
	localparam logic [7:0] PAFM_OFF_MISC = 8'h09;
	localparam logic [7:0] PAFM_OFF_CLK_MODE = 8'h0A;
	localparam logic [7:0] PAFM_OFF_BITOP = 8'h0B;
	localparam logic [7:0] PAFM_OFF_STATUS = 8'h0C;
	localparam logic [7:0] PAFM_OFF_AUX = 8'h0D;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] PAFM_RST_ZERO = 8'h00;
	localparam logic [7:0] PAFM_RST_DIR = 8'hFF;
	localparam logic [7:0] PAFM_RST_ANALOG = 8'hFF;
	localparam logic [3:0] PAFM_RST_SER_LEV = 4'hF;
	localparam logic [1:0] PAFM_RST_AUX = 2'h2;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int PAFM_REDIR_BUZ = 0;
	localparam int PAFM_REDIR_TMR1 = 1;
	localparam int PAFM_REDIR_IRQ1 = 2;
	localparam int PAFM_MISC_I2C = 0;
	localparam int PAFM_MISC_BUZ = 1;
	localparam int PAFM_CM_EXT = 7;
	localparam int PAFM_CM_OSC = 6;
	localparam int PAFM_BITOP_VAL = 7;
	localparam int PAFM_AUX_LATCH = 0;
	localparam int PAFM_AUX_DIR = 1;
	localparam int PAFM_IRQ1_PIN_A = 0;
	localparam int PAFM_IRQ1_PIN_B = 3;

	// Oscillator pin modes, {ext_clock_select, osc_pin_select}
	localparam logic [1:0] PAFM_OSC_RESONATOR = 2'h1;
	localparam logic [1:0] PAFM_OSC_EXT_CLK = 2'h3;

	// Raw outputs of the on-chip peripherals
	typedef struct packed {
		logic [1:0] ser_data;
		logic [1:0] ser_clk;
		logic [3:0] tmr;
		logic i2c_scl;
		logic i2c_sda;
		logic buz;
	} pafm_periph_t;

	// Read-modify-write sequencer for single-bit port writes
	typedef enum logic [1:0] {
		PAFM_S_IDLE,
		PAFM_S_READ,
		PAFM_S_MODIFY,
		PAFM_S_WRITE
	} pafm_rmw_st_t;

endpackage

// ### hdl/pafm_pin_cell.sv
`timescale 1ns/1ps
module pafm_pin_cell (
	input wire logic ref_clk, // System clock
	input wire logic rstn, // Async reset, active low
	input wire logic latch, // Port output latch bit
	input wire logic ser, // Serial-unit output, idle high
	input wire logic nonser, // OR of non-serial outputs, idle low
	input wire logic dir_in, // Direction, 1 = input
	input wire logic analog, // Analog select
	input wire logic open_drain, // Open-drain select
	output logic pin_out, // Pin output level
	output logic pin_oe_n // Pin output enable, low drives
);
	logic next_pin_out;
	logic next_pin_oe_n;
	logic level;
	logic drive;

	// ****************************************************************
	// Output combining gate
	// ****************************************************************
	// Open drain only pulls low, so a high level leaves the buffer off
	always_comb begin
		level = (latch & ser) | nonser; // R14
		drive = !dir_in && !analog; // R8
		next_pin_oe_n = !(drive && (!open_drain || !level));
		next_pin_out = open_drain ? 1'b0 : level;
	end

	// Registered so the pin never glitches on register writes
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pin_out <= 1'b0;
			pin_oe_n <= 1'b1;
		end else begin
			pin_out <= next_pin_out;
			pin_oe_n <= next_pin_oe_n;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	a_input_no_drive: assert property ((dir_in || analog) |=> pin_oe_n) // R8
		else $error("input pin is driven");
	a_combine_gate: assert property ( // R14
		(!dir_in && !analog && !open_drain) |=>
		(!pin_oe_n && pin_out == $past((latch & ser) | nonser)))
		else $error("pin level differs from combining gate");
endmodule

// ### bench/pafm_far_side.sv
`timescale 1ns/1ps
module pafm_far_side (
	input wire logic [8:0] pin_out, // Levels from the mux
	input wire logic [8:0] pin_oe_n, // Enables, low drives
	input wire logic [8:0] board_level, // Level the board puts on a free pin
	output logic [8:0] pin_in // Resolved pin levels
);
	// ****************************************************************
	// Pin resolution
	// ****************************************************************
	// A pin the mux drives shows its level; a released pin shows the board,
	// so a mux that forgets to release a pin is seen in the port view
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			pin_in[i] = (pin_oe_n[i] == 1'b0) ? pin_out[i] : board_level[i];
		end
	end
endmodule

// ### bench/port_alternate_function_mux_bench.sv
`timescale 1ns/1ps
module port_alternate_function_mux_bench;
	import pafm_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} pafm_row_t;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic [7:0] rv;
	pafm_periph_t periph = '{ser_data: 2'h3, ser_clk: 2'h3, default: '0};
	logic [8:0] pin_in, pin_out, pin_oe_n;
	logic [8:0] board_level = 9'h0_13C;
	logic ext_irq_1, i2c_unit_enable, clk_buzzer_out_enable;
	logic osc_port_mode, osc_resonator_en, osc_ext_clk_en;
	logic [1:0] ser_run;
	int err_count = 0;
	int total_checks = 0;
	pafm_row_t rows [11];
	pafm_mux i_dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .periph(periph), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .ext_irq_1(ext_irq_1), .ser_run(ser_run),
		.i2c_unit_enable(i2c_unit_enable), .clk_buzzer_out_enable(clk_buzzer_out_enable),
		.osc_port_mode(osc_port_mode), .osc_resonator_en(osc_resonator_en),
		.osc_ext_clk_en(osc_ext_clk_en));
	pafm_far_side i_far (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .board_level(board_level),
		.pin_in(pin_in));
	// ****************************************************************
	// Clock, tasks
	// ****************************************************************
	// 50 MHz system clock
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		total_checks++;
		if (seen !== exp) begin
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			err_count++;
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe, so sample right there
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Pins follow a register write two edges later
	task automatic settle();
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task automatic do_reset();
		@(posedge ref_clk);
		rstn <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Watchdog; the whole sequence needs well under a thousand cycles
	initial begin
		#100000;
		err_count++;
		wrap_up();
	end
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		rows = '{'{PAFM_OFF_DIR, 8'h5A, 8'h5A}, '{PAFM_OFF_ANALOG, 8'h3C, 8'h3C},
			'{PAFM_OFF_ODRAIN, 8'h81, 8'h81}, '{PAFM_OFF_REDIR, 8'hFF, 8'h07},
			'{PAFM_OFF_SER_CTRL, 8'hFF, 8'h0F}, '{PAFM_OFF_SER_LEV, 8'h05, 8'h05},
			'{PAFM_OFF_TMR_OE, 8'hFF, 8'h0F}, '{PAFM_OFF_TMR_LEV, 8'h0A, 8'h0A},
			'{PAFM_OFF_MISC, 8'hFF, 8'h03}, '{PAFM_OFF_STATUS, 8'hFF, 8'h00},
			'{8'h0E, 8'hFF, 8'h00}};
		do_reset();
		// Register access rows: write, then read back
		foreach (rows[i]) begin
			wr_reg(rows[i].a, rows[i].d);
			rd_reg(rows[i].a, rv);
			check(rv, rows[i].e);
		end
		// Second reset in mid-run must restore pin enables, unit enables and the direction, serial level, timer and misc defaults
		do_reset();
		#1 check(pin_oe_n, 9'h1FF);
		check(ser_run, 2'h0);
		check({i2c_unit_enable, clk_buzzer_out_enable}, 2'h0);
		rd_reg(PAFM_OFF_DIR, rv);
		check(rv, PAFM_RST_DIR);
		rd_reg(PAFM_OFF_SER_LEV, rv);
		check(rv, 8'h0F);
		rd_reg(PAFM_OFF_TMR_LEV, rv);
		check(rv, 8'h00);
		rd_reg(PAFM_OFF_TMR_OE, rv);
		check(rv, 8'h00);
		rd_reg(PAFM_OFF_MISC, rv);
		check(rv, 8'h00);
		// Port view: latch for output bits, pin for input bits
		wr_reg(PAFM_OFF_DIR, 8'h0F);
		wr_reg(PAFM_OFF_PORT, 8'hA5);
		rd_reg(PAFM_OFF_PORT, rv);
		check(rv, 8'hAC);
		// Single-bit set on bit 0 copies the high input pins into the latch
		board_level <= 9'h0_FF;
		wr_reg(PAFM_OFF_DIR, 8'hFE);
		wr_reg(PAFM_OFF_PORT, 8'h00);
		wr_reg(PAFM_OFF_BITOP, 8'h80);
		rd_reg(PAFM_OFF_STATUS, rv);
		check(rv[0], 1'b1);
		repeat (4) @(posedge ref_clk);
		wr_reg(PAFM_OFF_DIR, 8'h00);
		rd_reg(PAFM_OFF_PORT, rv);
		check(rv, 8'hFF);
		// Pin combining with every function idle, latch 1 on serial pin 0 only
		do_reset();
		periph <= '{ser_data: 2'h2, ser_clk: 2'h3, tmr: 4'hF, i2c_scl: 1'b1, i2c_sda: 1'b0,
			buz: 1'b1};
		wr_reg(PAFM_OFF_ANALOG, 8'h00);
		wr_reg(PAFM_OFF_DIR, 8'h00);
		wr_reg(PAFM_OFF_PORT, 8'h01);
		settle();
		check(pin_oe_n[7:0], 8'h00);
		check(pin_out[7:0], 8'h01);
		// Enable serial 0, timer 0, I2C and buzzer; serial raw data low gates pin 0
		wr_reg(PAFM_OFF_TMR_OE, 8'h01);
		wr_reg(PAFM_OFF_MISC, 8'h03);
		wr_reg(PAFM_OFF_SER_CTRL, 8'h05);
		settle();
		check(pin_out[7:0], 8'h4C);
		check({ser_run, i2c_unit_enable, clk_buzzer_out_enable}, 4'h7);
		// Open drain on pins 0 and 3 only pulls low, a high level floats
		wr_reg(PAFM_OFF_ODRAIN, 8'h09);
		settle();
		check(pin_oe_n[3:0], 4'h8);
		check(pin_out[3:0], 4'h4);
		// Input pins release every output even with functions running
		wr_reg(PAFM_OFF_DIR, 8'hFF);
		settle();
		check(pin_oe_n, 9'h1FF);
		// Buzzer redirected to the aux pin
		wr_reg(PAFM_OFF_REDIR, 8'h01);
		wr_reg(PAFM_OFF_AUX, 8'h00);
		settle();
		check({pin_oe_n[8], pin_out[8]}, 2'b01);
		// Units left unused are switched off; the aux pin then follows its latch
		wr_reg(PAFM_OFF_MISC, 8'h00);
		wr_reg(PAFM_OFF_SER_CTRL, 8'h00);
		wr_reg(PAFM_OFF_TMR_OE, 8'h00);
		settle();
		check({ser_run, i2c_unit_enable, clk_buzzer_out_enable}, 4'h0);
		check({pin_oe_n[8], pin_out[8]}, 2'b00);
		// Interrupt 1 follows pin 0, then pin 3 once redirected
		board_level <= 9'h0_01;
		settle();
		check(ext_irq_1, 1'b1);
		wr_reg(PAFM_OFF_REDIR, 8'h04);
		settle();
		check(ext_irq_1, 1'b0);
		board_level <= 9'h0_08;
		settle();
		check(ext_irq_1, 1'b1);
		// Every oscillator pin mode; the register takes only its first write
		for (int m = 0; m < 4; m++) begin
			do_reset();
			wr_reg(PAFM_OFF_CLK_MODE, {m[1:0], 6'h00});
			settle();
			check({osc_port_mode, osc_resonator_en, osc_ext_clk_en},
				{(m == 0 || m == 2), (m == 1), (m == 3)});
		end
		wr_reg(PAFM_OFF_CLK_MODE, 8'h00);
		rd_reg(PAFM_OFF_CLK_MODE, rv);
		check(rv, 8'hC0);
		wrap_up();
	end
endmodule
